// ===== pkg/sebfe_pkg.sv
// shared constants for the serial eeprom bus front end
package sebfe_pkg;

    // core clock rate and the programming interval as printed
    localparam int CLK_HZ               = 25_000_000;
    localparam int T_PROGRAM_MS         = 5;
    // longest time: round down, never below one cycle
    localparam int PROGRAM_CYCLES_RAW   = (T_PROGRAM_MS * (CLK_HZ / 1000));
    localparam int PROGRAM_CYCLES       = (PROGRAM_CYCLES_RAW < 1) ? 1 : PROGRAM_CYCLES_RAW;

    // word layout
    localparam int WORD_BITS            = 8;
    localparam int ACK_SLOT             = 8;
    localparam int TYPE_MSB             = 7;
    localparam int TYPE_LSB             = 4;
    localparam int SELECT_MSB           = 3;
    localparam int SELECT_LSB           = 1;
    localparam int DIR_BIT              = 0;

    // arbitrary value, the real device-type code is set at instantiation
    localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h5;

    // reset values and the byte index limit
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam logic [7:0] WORD_RESET      = 8'h00;
    localparam logic [7:0] BYTE_INDEX_MAX  = 8'hff;

    // synchroniser bundle positions
    localparam int SYNC_WIDTH           = 6;
    localparam int SYNC_SCL             = 0;
    localparam int SYNC_SDA             = 1;
    localparam int SYNC_WP              = 2;
    localparam int SYNC_SEL_LOW         = 3;
    localparam int SYNC_SEL_MID         = 4;
    localparam int SYNC_SEL_HIGH        = 5;

    typedef enum logic [8:0] {
        SEBFE_IDLE     = 9'h001,
        SEBFE_ADDR     = 9'h002,
        SEBFE_ADDR_ACK = 9'h004,
        SEBFE_RX       = 9'h008,
        SEBFE_RX_ACK   = 9'h010,
        SEBFE_TX       = 9'h020,
        SEBFE_TX_ACK   = 9'h040,
        SEBFE_IGNORE   = 9'h080,
        SEBFE_PROGRAM  = 9'h100
    } sebfe_state_t;

endpackage : sebfe_pkg

// ===== design/sebfe_sync.sv
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps

module sebfe_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("sebfe_sync: WIDTH must be at least 1");
        end
    endgenerate

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule : sebfe_sync

// ===== design/sebfe_top.sv
// target-side front end of a two-wire serial eeprom
`timescale 1ns/100ps

module sebfe_top #(
    parameter int         PROGRAM_CYCLES = sebfe_pkg::PROGRAM_CYCLES,
    parameter logic [3:0] DEVICE_TYPE    = sebfe_pkg::DEVICE_TYPE_DEFAULT
) (
    input  wire logic       CORE_CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_OUT,
    input  wire logic       WP_IN,
    input  wire logic       STRAP_SELECT_HIGH_IN,
    input  wire logic       STRAP_SELECT_MID_IN,
    input  wire logic       STRAP_SELECT_LOW_IN,
    input  wire logic [7:0] TX_DATA_IN,
    output logic            TX_LOAD_OUT,
    output logic [7:0]      RX_DATA_OUT,
    output logic            RX_VALID_OUT,
    output logic [7:0]      RX_INDEX_OUT,
    output logic            SELECTED_OUT,
    output logic            READ_MODE_OUT,
    output logic            COMMIT_OUT,
    output logic            BUSY_OUT,
    output logic            STANDBY_OUT
);

    localparam int TW = $clog2(PROGRAM_CYCLES + 1);

    generate
        if (PROGRAM_CYCLES < 1) begin : g_bad_cycles
            $error("sebfe_top: PROGRAM_CYCLES must be at least 1");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and bus event detection

    logic [sebfe_pkg::SYNC_WIDTH-1:0] pins_async;
    logic [sebfe_pkg::SYNC_WIDTH-1:0] pins_sync;

    // bus lines stored inverted: a cleared synchroniser then reads as an idle high bus, no false edge
    assign pins_async[sebfe_pkg::SYNC_SCL]      = ~SCL_IN;
    assign pins_async[sebfe_pkg::SYNC_SDA]      = ~SDA_IN;
    assign pins_async[sebfe_pkg::SYNC_WP]       = WP_IN;
    assign pins_async[sebfe_pkg::SYNC_SEL_LOW]  = STRAP_SELECT_LOW_IN;
    assign pins_async[sebfe_pkg::SYNC_SEL_MID]  = STRAP_SELECT_MID_IN;
    assign pins_async[sebfe_pkg::SYNC_SEL_HIGH] = STRAP_SELECT_HIGH_IN;

    sebfe_sync #(
        .WIDTH (sebfe_pkg::SYNC_WIDTH)
    ) u_sync (
        .clk_in   (CORE_CLK_IN),
        .rst_n_in (RST_N_IN),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic [2:0] strap_s;

    assign scl_s   = ~pins_sync[sebfe_pkg::SYNC_SCL];
    assign sda_s   = ~pins_sync[sebfe_pkg::SYNC_SDA];
    assign wp_s    = pins_sync[sebfe_pkg::SYNC_WP];
    // a floating strap is pulled down at the pad, so it arrives here as 0
    assign strap_s = {pins_sync[sebfe_pkg::SYNC_SEL_HIGH],
                      pins_sync[sebfe_pkg::SYNC_SEL_MID],
                      pins_sync[sebfe_pkg::SYNC_SEL_LOW]};

    logic scl_q_reg;
    logic sda_q_reg;

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_s & ~scl_q_reg;
    assign scl_fall  = ~scl_s & scl_q_reg;
    // data moving while the clock stays high is framing, never data
    assign bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign bus_stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic addr_match(input logic [7:0] word,
                                        input logic [2:0] straps,
                                        input logic [3:0] dev_type);
        logic type_ok;
        logic sel_ok;
        type_ok = (word[sebfe_pkg::TYPE_MSB:sebfe_pkg::TYPE_LSB] == dev_type);
        sel_ok  = (word[sebfe_pkg::SELECT_MSB:sebfe_pkg::SELECT_LSB] == straps);
        return type_ok & sel_ok;
    endfunction : addr_match

    function automatic logic [3:0] bit_inc(input logic [3:0] count);
        return (count == 4'(sebfe_pkg::ACK_SLOT)) ? count : 4'(count + 4'h1);
    endfunction : bit_inc

    ////////////////////////////////////////////////////////////////////////////
    // protocol state

    sebfe_pkg::sebfe_state_t state_reg;
    sebfe_pkg::sebfe_state_t state_next;
    logic [3:0]              bit_cnt_reg;
    logic [3:0]              bit_cnt_next;
    logic [7:0]              shift_reg;
    logic [7:0]              shift_next;
    logic [7:0]              tx_shift_reg;
    logic [7:0]              tx_shift_next;
    logic [7:0]              rx_data_reg;
    logic [7:0]              rx_data_next;
    logic [7:0]              rx_index_reg;
    logic [7:0]              rx_index_next;
    logic                    drive_low_reg;
    logic                    drive_low_next;
    logic                    read_reg;
    logic                    read_next;
    logic                    data_seen_reg;
    logic                    data_seen_next;
    logic                    host_ack_reg;
    logic                    host_ack_next;
    logic                    rx_valid_reg;
    logic                    rx_valid_next;
    logic                    tx_load_reg;
    logic                    tx_load_next;
    logic                    commit_reg;
    logic                    commit_next;
    logic [TW-1:0]           prog_cnt_reg;
    logic [TW-1:0]           prog_cnt_next;

    always_comb begin
        state_next     = state_reg;
        bit_cnt_next   = bit_cnt_reg;
        shift_next     = shift_reg;
        tx_shift_next  = tx_shift_reg;
        rx_data_next   = rx_data_reg;
        rx_index_next  = rx_index_reg;
        drive_low_next = drive_low_reg;
        read_next      = read_reg;
        data_seen_next = data_seen_reg;
        host_ack_next  = host_ack_reg;
        rx_valid_next  = 1'b0;
        tx_load_next   = 1'b0;
        commit_next    = 1'b0;
        prog_cnt_next  = prog_cnt_reg;

        if (state_reg == sebfe_pkg::SEBFE_PROGRAM) begin
            // bus is deaf while the array programs
            drive_low_next = 1'b0;
            if (prog_cnt_reg == '0) begin
                state_next = sebfe_pkg::SEBFE_IDLE;
            end else begin
                prog_cnt_next = TW'(prog_cnt_reg - 1'b1);
            end
        end else if (bus_start) begin
            // also the exit path of the recovery sequence
            state_next     = sebfe_pkg::SEBFE_ADDR;
            bit_cnt_next   = sebfe_pkg::BIT_COUNT_RESET;
            drive_low_next = 1'b0;
            data_seen_next = 1'b0;
            read_next      = 1'b0;
            rx_index_next  = sebfe_pkg::WORD_RESET;
        end else if (bus_stop) begin
            drive_low_next = 1'b0;
            if ((state_reg == sebfe_pkg::SEBFE_RX || state_reg == sebfe_pkg::SEBFE_RX_ACK)
                && data_seen_reg && !wp_s) begin
                state_next    = sebfe_pkg::SEBFE_PROGRAM;
                prog_cnt_next = TW'(PROGRAM_CYCLES - 1);
                commit_next   = 1'b1;
            end else begin
                // read end, protected write end or stray stop
                state_next = sebfe_pkg::SEBFE_IDLE;
            end
        end else begin
            unique case (state_reg)
                sebfe_pkg::SEBFE_IDLE,
                sebfe_pkg::SEBFE_IGNORE: begin
                    drive_low_next = 1'b0;
                end
                sebfe_pkg::SEBFE_ADDR: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_inc(bit_cnt_reg);
                    end else if (scl_fall && bit_cnt_reg == 4'(sebfe_pkg::ACK_SLOT)) begin
                        bit_cnt_next = sebfe_pkg::BIT_COUNT_RESET;
                        if (addr_match(shift_reg, strap_s, DEVICE_TYPE)) begin
                            state_next     = sebfe_pkg::SEBFE_ADDR_ACK;
                            drive_low_next = 1'b1;
                            read_next      = shift_reg[sebfe_pkg::DIR_BIT];
                        end else begin
                            state_next     = sebfe_pkg::SEBFE_IGNORE;
                            drive_low_next = 1'b0;
                        end
                    end
                end
                sebfe_pkg::SEBFE_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = sebfe_pkg::BIT_COUNT_RESET;
                        if (read_reg) begin
                            state_next     = sebfe_pkg::SEBFE_TX;
                            tx_shift_next  = TX_DATA_IN;
                            tx_load_next   = 1'b1;
                            drive_low_next = ~TX_DATA_IN[7];
                        end else begin
                            state_next     = sebfe_pkg::SEBFE_RX;
                            drive_low_next = 1'b0;
                        end
                    end
                end
                sebfe_pkg::SEBFE_RX: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_inc(bit_cnt_reg);
                    end else if (scl_fall && bit_cnt_reg == 4'(sebfe_pkg::ACK_SLOT)) begin
                        // word is acknowledged even when protected; only the commit is refused
                        state_next     = sebfe_pkg::SEBFE_RX_ACK;
                        bit_cnt_next   = sebfe_pkg::BIT_COUNT_RESET;
                        drive_low_next = 1'b1;
                        rx_data_next   = shift_reg;
                        rx_valid_next  = 1'b1;
                        data_seen_next = 1'b1;
                    end
                end
                sebfe_pkg::SEBFE_RX_ACK: begin
                    if (scl_fall) begin
                        state_next     = sebfe_pkg::SEBFE_RX;
                        drive_low_next = 1'b0;
                        if (rx_index_reg != sebfe_pkg::BYTE_INDEX_MAX) begin
                            rx_index_next = 8'(rx_index_reg + 8'h01);
                        end
                    end
                end
                sebfe_pkg::SEBFE_TX: begin
                    if (scl_rise) begin
                        bit_cnt_next = bit_inc(bit_cnt_reg);
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == 4'(sebfe_pkg::ACK_SLOT)) begin
                            // the controller owns the ninth clock
                            state_next     = sebfe_pkg::SEBFE_TX_ACK;
                            drive_low_next = 1'b0;
                            host_ack_next  = 1'b0;
                        end else begin
                            tx_shift_next  = {tx_shift_reg[6:0], 1'b0};
                            drive_low_next = ~tx_shift_reg[6];
                        end
                    end
                end
                sebfe_pkg::SEBFE_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            // no acknowledge: wait for the stop
                            state_next = sebfe_pkg::SEBFE_IGNORE;
                        end else begin
                            host_ack_next = 1'b1;
                        end
                    end else if (scl_fall && host_ack_reg) begin
                        state_next     = sebfe_pkg::SEBFE_TX;
                        bit_cnt_next   = sebfe_pkg::BIT_COUNT_RESET;
                        tx_shift_next  = TX_DATA_IN;
                        tx_load_next   = 1'b1;
                        drive_low_next = ~TX_DATA_IN[7];
                    end
                end
                default: begin
                    state_next     = sebfe_pkg::SEBFE_IDLE;
                    drive_low_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg     <= sebfe_pkg::SEBFE_IDLE;
            bit_cnt_reg   <= sebfe_pkg::BIT_COUNT_RESET;
            shift_reg     <= sebfe_pkg::WORD_RESET;
            tx_shift_reg  <= sebfe_pkg::WORD_RESET;
            rx_data_reg   <= sebfe_pkg::WORD_RESET;
            rx_index_reg  <= sebfe_pkg::WORD_RESET;
            drive_low_reg <= 1'b0;
            read_reg      <= 1'b0;
            data_seen_reg <= 1'b0;
            host_ack_reg  <= 1'b0;
            rx_valid_reg  <= 1'b0;
            tx_load_reg   <= 1'b0;
            commit_reg    <= 1'b0;
            prog_cnt_reg  <= '0;
        end else begin
            state_reg     <= state_next;
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            tx_shift_reg  <= tx_shift_next;
            rx_data_reg   <= rx_data_next;
            rx_index_reg  <= rx_index_next;
            drive_low_reg <= drive_low_next;
            read_reg      <= read_next;
            data_seen_reg <= data_seen_next;
            host_ack_reg  <= host_ack_next;
            rx_valid_reg  <= rx_valid_next;
            tx_load_reg   <= tx_load_next;
            commit_reg    <= commit_next;
            prog_cnt_reg  <= prog_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // open drain: the pin only ever pulls low
    assign SDA_OUT       = 1'b0;
    assign SDA_OE_OUT    = drive_low_reg;
    assign TX_LOAD_OUT   = tx_load_reg;
    assign RX_DATA_OUT   = rx_data_reg;
    assign RX_VALID_OUT  = rx_valid_reg;
    assign RX_INDEX_OUT  = rx_index_reg;
    assign SELECTED_OUT  = (state_reg == sebfe_pkg::SEBFE_ADDR_ACK) || (state_reg == sebfe_pkg::SEBFE_RX)
                           || (state_reg == sebfe_pkg::SEBFE_RX_ACK) || (state_reg == sebfe_pkg::SEBFE_TX)
                           || (state_reg == sebfe_pkg::SEBFE_TX_ACK);
    assign READ_MODE_OUT = read_reg;
    // gated by protect at the stop, so a protected write never reaches the array
    assign COMMIT_OUT    = commit_reg;
    assign BUSY_OUT      = (state_reg == sebfe_pkg::SEBFE_PROGRAM);
    assign STANDBY_OUT   = (state_reg == sebfe_pkg::SEBFE_IDLE) || (state_reg == sebfe_pkg::SEBFE_IGNORE);

endmodule : sebfe_top

// ===== verification/sebfe_chk.sv
// port-level assertions for the serial eeprom bus front end
`timescale 1ns/100ps
module sebfe_chk #(
    parameter int PROGRAM_CYCLES = 20
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic SCL_IN,
    input wire logic WP_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    input wire logic RX_VALID_OUT,
    input wire logic TX_LOAD_OUT,
    input wire logic SELECTED_OUT,
    input wire logic READ_MODE_OUT,
    input wire logic COMMIT_OUT,
    input wire logic BUSY_OUT,
    input wire logic STANDBY_OUT
);
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;
    always_comb begin
        busy_cnt_next = BUSY_OUT ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_open_drain; SDA_OUT == 1'b0; endproperty
    property p_oe_scl_low; $changed(SDA_OE_OUT) |-> !SCL_IN; endproperty
    property p_ack_selected; $rose(SDA_OE_OUT) |-> SELECTED_OUT; endproperty
    property p_standby_quiet; STANDBY_OUT |-> !SDA_OE_OUT && !SELECTED_OUT; endproperty
    property p_busy_deaf; BUSY_OUT |-> !SDA_OE_OUT && !SELECTED_OUT; endproperty
    property p_commit_busy; COMMIT_OUT |=> BUSY_OUT && !COMMIT_OUT; endproperty
    property p_busy_bound; BUSY_OUT |-> busy_cnt_reg < PROGRAM_CYCLES; endproperty
    property p_commit_wp; COMMIT_OUT |-> !WP_IN; endproperty
    property p_rx_write; RX_VALID_OUT |-> SELECTED_OUT && !READ_MODE_OUT; endproperty
    property p_tx_read; TX_LOAD_OUT |-> READ_MODE_OUT; endproperty
    property p_busy_end; $fell(BUSY_OUT) |-> ##[0:2] STANDBY_OUT; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data value not zero");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive moved with clock high");
    a_ack_selected: assert property (p_ack_selected) else $error("pull while not selected");
    a_standby_quiet: assert property (p_standby_quiet) else $error("drive in standby");
    a_busy_deaf: assert property (p_busy_deaf) else $error("bus answered while programming");
    a_commit_busy: assert property (p_commit_busy) else $error("commit without busy");
    a_busy_bound: assert property (p_busy_bound) else $error("programming too long");
    a_commit_wp: assert property (p_commit_wp) else $error("commit while protected");
    a_rx_write: assert property (p_rx_write) else $error("receive outside write");
    a_tx_read: assert property (p_tx_read) else $error("load outside read");
    a_busy_end: assert property (p_busy_end) else $error("no standby after programming");
    c_commit: cover property (COMMIT_OUT);
    c_load: cover property (TX_LOAD_OUT);
    c_busy_end: cover property ($fell(BUSY_OUT));
endmodule : sebfe_chk

bind sebfe_top sebfe_chk #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) sebfe_chk_inst (.CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN), .SCL_IN(SCL_IN), .WP_IN(WP_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
    .RX_VALID_OUT(RX_VALID_OUT), .TX_LOAD_OUT(TX_LOAD_OUT), .SELECTED_OUT(SELECTED_OUT),
    .READ_MODE_OUT(READ_MODE_OUT), .COMMIT_OUT(COMMIT_OUT), .BUSY_OUT(BUSY_OUT), .STANDBY_OUT(STANDBY_OUT));

// ===== verification/sebfe_ctl_model.sv
// two-wire bus controller model: drives the serial clock and pulls the data line
`timescale 1ns/100ps
module sebfe_ctl_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // clock stands high between frames
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wait_cyc
    // data moves one cycle after the clock falls, clock low 5 and high 3 cycles
    task automatic put_bit(input logic b, output logic r);
        wait_cyc(1);
        sda_low_out = !b;
        wait_cyc(4);
        scl_out = 1'b1;
        wait_cyc(3);
        r = sda_in;
        scl_out = 1'b0;
    endtask : put_bit
    task automatic start_cond();
        wait_cyc(1);
        sda_low_out = 1'b0;
        wait_cyc(4);
        scl_out = 1'b1;
        wait_cyc(3);
        sda_low_out = 1'b1;
        wait_cyc(3);
        scl_out = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        wait_cyc(1);
        sda_low_out = 1'b1;
        wait_cyc(4);
        scl_out = 1'b1;
        wait_cyc(3);
        sda_low_out = 1'b0;
        wait_cyc(3);
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = !r;
    endtask : send_byte
    task automatic recv_byte(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(!give_ack, r);
    endtask : recv_byte
    task automatic recover();
        logic r;
        start_cond();
        repeat (9) put_bit(1'b1, r);
        start_cond();
        stop_cond();
    endtask : recover
endmodule : sebfe_ctl_model

// ===== verification/testbench.sv
// self-checking bench for the serial eeprom bus front end
`timescale 1ns/100ps
module testbench;
    localparam int         PROG = 200;
    localparam logic [3:0] DEV  = 4'h9; // arbitrary device-type code
    logic       clk;
    logic       rst_n;
    logic       scl;
    logic       ctl_low;
    logic       oe;
    logic       wp;
    logic [2:0] straps;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [7:0] rx_index;
    logic       busy;
    logic       standby;
    logic [7:0] d;
    logic       ack;
    int         fail_count = 0;
    int         samples_checked = 0;
    wire        sda = (ctl_low || oe) ? 1'b0 : 1'b1;
    sebfe_top #(.PROGRAM_CYCLES(PROG), .DEVICE_TYPE(DEV)) sebfe_top_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(oe), .WP_IN(wp), .STRAP_SELECT_HIGH_IN(straps[2]),
        .STRAP_SELECT_MID_IN(straps[1]), .STRAP_SELECT_LOW_IN(straps[0]), .TX_DATA_IN(tx_data), .TX_LOAD_OUT(),
        .RX_DATA_OUT(rx_data), .RX_VALID_OUT(), .RX_INDEX_OUT(rx_index), .SELECTED_OUT(), .READ_MODE_OUT(),
        .COMMIT_OUT(), .BUSY_OUT(busy), .STANDBY_OUT(standby));
    sebfe_ctl_model sebfe_ctl_model_inst (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(ctl_low));
    ////////////////////////////////////////////////////////////////
    function automatic logic addr_hit(input logic [7:0] a, input logic [2:0] s);
        return (a[7:4] === DEV) && (a[3:1] === s);
    endfunction : addr_hit
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // one random transaction; poll during programming must go unanswered
    task automatic run_one(input int n);
        logic [7:0] a;
        logic       hit;
        int         nb;
        straps = 3'($urandom);
        wp = 1'($urandom);
        tx_data = 8'($urandom);
        a = 8'($urandom);
        if (n % 3 != 2) a[7:4] = DEV;
        if (n % 2 == 0) a[3:1] = straps;
        hit = addr_hit(a, straps);
        repeat (4) @(negedge clk);
        sebfe_ctl_model_inst.start_cond();
        sebfe_ctl_model_inst.send_byte(a, ack);
        check("address ack", 8'(ack), 8'(hit));
        if (!hit) begin
            check("standby on miss", 8'(standby), 8'h01);
        end else if (a[0]) begin
            sebfe_ctl_model_inst.recv_byte(1'b1, d);
            check("read byte", d, tx_data);
            // next byte is loaded at the fall that ends the controller acknowledge
            tx_data = 8'($urandom);
            sebfe_ctl_model_inst.recv_byte(1'b0, d);
            check("next read byte", d, tx_data);
        end else begin
            nb = $urandom_range(3, 1);
            for (int k = 0; k < nb; k++) begin
                d = 8'($urandom);
                sebfe_ctl_model_inst.send_byte(d, ack);
                check("data ack", 8'(ack), 8'h01);
                check("rx data", rx_data, d);
                check("rx index", rx_index, 8'(k));
            end
        end
        sebfe_ctl_model_inst.stop_cond();
        repeat (5) @(negedge clk);
        check("busy", 8'(busy), 8'(hit && !a[0] && !wp));
        if (hit && !a[0] && !wp) begin
            sebfe_ctl_model_inst.start_cond();
            sebfe_ctl_model_inst.send_byte({DEV, straps, 1'b0}, ack);
            check("poll ack", 8'(ack), 8'h00);
            sebfe_ctl_model_inst.stop_cond();
            for (int i = 0; i < 400 && busy; i++) @(negedge clk);
        end
        repeat (4) @(negedge clk);
        check("standby", 8'(standby), 8'h01);
    endtask : run_one
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        straps = 3'h0;
        tx_data = 8'h00;
        void'($urandom(64));
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("standby at reset", 8'(standby), 8'h01);
        check("busy at reset", 8'(busy), 8'h00);
        sebfe_ctl_model_inst.start_cond();
        sebfe_ctl_model_inst.send_byte({DEV, 4'h0}, ack);
        sebfe_ctl_model_inst.recover();
        check("standby after recovery", 8'(standby), 8'h01);
        // straps low as if floating: zero select bits must match
        sebfe_ctl_model_inst.start_cond();
        sebfe_ctl_model_inst.send_byte({DEV, 3'h0, 1'b0}, ack);
        check("write address ack", 8'(ack), 8'h01);
        tx_data = 8'h5a;
        sebfe_ctl_model_inst.start_cond();
        sebfe_ctl_model_inst.send_byte({DEV, 3'h0, 1'b1}, ack);
        check("repeated start ack", 8'(ack), 8'h01);
        sebfe_ctl_model_inst.recv_byte(1'b0, d);
        check("read byte", d, 8'h5a);
        sebfe_ctl_model_inst.stop_cond();
        repeat (4) @(negedge clk);
        check("standby after read", 8'(standby), 8'h01);
        for (int n = 0; n < 14; n++) begin
            run_one(n);
        end
        close_out();
    end
endmodule : testbench
